// ==== design/fph_cycle.sv ====
// One flash bus cycle: a strobed write or an output-enabled read
`timescale 1ns/1ps
`default_nettype none
`include "fph_map.svh"
module fph_cycle import fph_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request and answer
  input wire logic start_i,
  input wire fph_req_s req_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  // Flash pins (dq_i already synchronised)
  input wire logic [15:0] dq_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [19:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o
);

  typedef enum logic [2:0] {
    FPH_C_IDLE = 3'h0, FPH_C_SETUP = 3'h1, FPH_C_STROBE = 3'h2,
    FPH_C_HOLD = 3'h3, FPH_C_GAP = 3'h4
  } fph_cst_e;

  fph_cst_e st_q;
  logic wr_q;
  logic [2:0] cnt_q;

  // Strobe sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= FPH_C_IDLE;
      wr_q <= 1'b0;
      cnt_q <= 3'h0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      addr_o <= 20'h00000;
      dq_o <= 16'h0000;
      dq_oe_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        FPH_C_IDLE: begin
          if (start_i) begin
            wr_q <= req_i.write;
            addr_o <= req_i.addr;
            dq_o <= req_i.data;
            dq_oe_o <= req_i.write;
            ce_n_o <= 1'b0;
            st_q <= FPH_C_SETUP;
          end
        end
        FPH_C_SETUP: begin
          if (wr_q) begin
            we_n_o <= 1'b0;
            cnt_q <= 3'(`FPH_WP_CYC - 1);
          end else begin
            oe_n_o <= 1'b0;
            cnt_q <= 3'(`FPH_RD_CYC - 1);
          end
          st_q <= FPH_C_STROBE;
        end
        FPH_C_STROBE: begin
          if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
          end else begin
            we_n_o <= 1'b1; // Write strobe rises before chip select
            oe_n_o <= 1'b1;
            if (!wr_q) begin
              rdata_o <= dq_i;
            end
            st_q <= FPH_C_HOLD;
          end
        end
        FPH_C_HOLD: begin
          ce_n_o <= 1'b1;
          dq_oe_o <= 1'b0;
          st_q <= FPH_C_GAP;
        end
        FPH_C_GAP: begin
          // Idle cycle keeps each status read a fresh strobe
          done_o <= 1'b1;
          st_q <= FPH_C_IDLE;
        end
        default: st_q <= FPH_C_IDLE;
      endcase
    end
  end

endmodule // fph_cycle
`default_nettype wire

// ==== design/fph_host.sv ====
// Flash host controller: Wishbone registers driving flash command sequences
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "fph_map.svh"
module fph_host import fph_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash pins
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic [19:0] flash_addr_o,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [15:0] flash_dq_i,
  output logic flash_rp_n_o,
  output logic flash_wp_n_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  typedef enum logic [2:0] {
    FPH_S_IDLE = 3'h0, FPH_S_PWR = 3'h1, FPH_S_CMD1 = 3'h2,
    FPH_S_PH2 = 3'h3, FPH_S_POLL = 3'h4
  } fph_state_e;

  fph_state_e st_q;
  fph_op_e op_q;
  fph_mode_e mode_q;
  logic [19:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [7:0] dstat_q;
  logic [2:0] fail_q;
  logic refused_q;
  logic rp_q;
  logic wp_q;
  logic [6:0] pidx_q;
  logic [6:0] pcnt_q;
  logic [5:0] pwr_cnt_q;
  logic pend_q;
  logic start_q;
  fph_req_s req_q;
  fph_req_s req_d;
  logic [15:0] page_mem [`FPH_PAGE_WORDS];

  logic [15:0] dq_sync;
  logic cyc_done;
  logic [15:0] cyc_rdata;

  logic wb_req;
  logic wb_wr;
  logic [31:0] wb_wdat;
  logic go;
  logic go_ok;
  logic pwr_ok;
  logic has_cmd;
  logic [7:0] cmd;
  fph_ph_e ph2;
  logic do_poll;
  logic need_susp;
  logic bank1_only;
  logic issue_st;
  logic stat_done;
  logic poll_end;
  logic seq_end;
  logic [7:0] stat_rd;

  // Byte lane merge for register writes
  function automatic logic [31:0] wmerge(
    input logic [31:0] o,
    input logic [31:0] n,
    input logic [3:0] s
  );
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  fph_sync2 #(.W(16)) u_dq_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(flash_dq_i),
    .q_o(dq_sync)
  );

  fph_cycle u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_q),
    .req_i(req_q),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .dq_i(dq_sync),
    .ce_n_o(flash_ce_n_o),
    .oe_n_o(flash_oe_n_o),
    .we_n_o(flash_we_n_o),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_o(flash_dq_oe_o)
  );

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  always_comb begin
    has_cmd = 1'b1;
    cmd = `FPH_CMD_READ_ARRAY;
    ph2 = FPH_PH_NONE;
    do_poll = 1'b0;
    need_susp = 1'b0;
    bank1_only = 1'b0;
    case (op_q)
      FPH_OP_READ_ARRAY: cmd = `FPH_CMD_READ_ARRAY;
      FPH_OP_READ_ID: begin
        cmd = `FPH_CMD_READ_ID;
        ph2 = FPH_PH_READ;
      end
      FPH_OP_READ_STAT: begin
        cmd = `FPH_CMD_READ_STAT;
        ph2 = FPH_PH_READ;
      end
      FPH_OP_CLR_STAT: cmd = `FPH_CMD_CLR_STAT;
      FPH_OP_ERASE: begin
        cmd = `FPH_CMD_ERASE;
        ph2 = FPH_PH_CONFIRM;
        do_poll = 1'b1;
      end
      FPH_OP_PROGRAM: begin
        cmd = `FPH_CMD_PROGRAM;
        ph2 = FPH_PH_DATA;
        do_poll = 1'b1;
        bank1_only = 1'b1;
      end
      FPH_OP_PAGE_PROG: begin
        cmd = `FPH_CMD_PAGE_PROG;
        ph2 = FPH_PH_PAGE;
        do_poll = 1'b1;
      end
      FPH_OP_PAGE_LOAD: begin
        cmd = `FPH_CMD_PAGE_LOAD;
        ph2 = FPH_PH_DATA;
        bank1_only = 1'b1;
      end
      FPH_OP_PAGE_FLUSH: begin
        cmd = `FPH_CMD_PAGE_FLUSH;
        ph2 = FPH_PH_CONFIRM;
        do_poll = 1'b1;
        bank1_only = 1'b1;
      end
      FPH_OP_PAGE_CLR: begin
        cmd = `FPH_CMD_PAGE_CLR;
        ph2 = FPH_PH_CONFIRM;
      end
      FPH_OP_SUSPEND: begin
        cmd = `FPH_CMD_SUSPEND;
        do_poll = 1'b1;
        need_susp = 1'b1;
      end
      FPH_OP_RESUME: cmd = `FPH_CMD_CONFIRM;
      FPH_OP_READ: begin
        has_cmd = 1'b0;
        ph2 = FPH_PH_READ;
      end
      FPH_OP_POLL: begin
        has_cmd = 1'b0;
        do_poll = 1'b1;
      end
      default: has_cmd = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Cycle request for the current state
  // ----------------------------------------
  always_comb begin
    req_d.write = 1'b1;
    req_d.addr = addr_q; // Bank address rides with every write
    req_d.data = {8'h00, cmd};
    if (st_q == FPH_S_POLL) begin
      req_d.write = 1'b0;
    end else if (st_q == FPH_S_PH2) begin
      case (ph2)
        FPH_PH_CONFIRM: req_d.data = {8'h00, `FPH_CMD_CONFIRM};
        FPH_PH_DATA: req_d.data = wdata_q;
        FPH_PH_READ: req_d.write = 1'b0;
        FPH_PH_PAGE: begin
          req_d.addr = {addr_q[19:7], pcnt_q};
          req_d.data = page_mem[pcnt_q];
        end
        default: req_d.write = 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // Sequence events
  // ----------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign wb_wdat = wmerge(32'h00000000, wb_dat_i, wb_sel_i);
  assign go = wb_wr && wb_adr_i == `FPH_REG_CTRL && wb_sel_i[1]
              && wb_dat_i[`FPH_CTRL_GO];
  assign pwr_ok = pwr_cnt_q == 6'(`FPH_PWR_CYC);
  assign issue_st = st_q == FPH_S_CMD1 || st_q == FPH_S_POLL
                    || (st_q == FPH_S_PH2 && ph2 != FPH_PH_NONE);
  assign stat_rd = cyc_rdata[7:0];
  assign poll_end = st_q == FPH_S_POLL && cyc_done && stat_rd[`FPH_SR_READY]
                    && (!need_susp || stat_rd[`FPH_SR_SUSP]);
  assign stat_done = cyc_done && (st_q == FPH_S_POLL
                     || (st_q == FPH_S_PH2 && op_q == FPH_OP_READ_STAT));
  assign seq_end = poll_end || (st_q == FPH_S_PH2 && !do_poll
                   && (ph2 == FPH_PH_NONE || (cyc_done && ph2 != FPH_PH_PAGE)
                   || (cyc_done && pcnt_q == 7'h7F)));

  // Program to second bank is refused before any pin moves when its go write names the op already held in op_q
  always_comb begin
    go_ok = st_q == FPH_S_IDLE && rp_q;
    if (bank1_only && fph_op_e'(wb_dat_i[3:0]) == op_q && addr_q > `FPH_BANK1_LIMIT) begin
      go_ok = 1'b0;
    end
  end

  // ----------------------------------------
  // Power-up wait after reset pin release
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !rp_q) begin
      pwr_cnt_q <= 6'h00;
    end else if (!pwr_ok) begin
      pwr_cnt_q <= pwr_cnt_q + 6'h01; // 2 us before any operation
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= FPH_S_IDLE;
      pend_q <= 1'b0;
      start_q <= 1'b0;
      req_q <= '0;
      pcnt_q <= 7'h00;
    end else begin
      start_q <= 1'b0;
      if (issue_st && !pend_q) begin
        start_q <= 1'b1;
        req_q <= req_d;
        pend_q <= 1'b1;
      end
      if (cyc_done) begin
        pend_q <= 1'b0;
      end
      case (st_q)
        FPH_S_IDLE: begin
          pcnt_q <= 7'h00;
          if (go && go_ok) begin
            st_q <= FPH_S_PWR;
          end
        end
        FPH_S_PWR: begin
          if (pwr_ok) begin
            st_q <= has_cmd ? FPH_S_CMD1 : FPH_S_PH2;
          end
        end
        FPH_S_CMD1: begin
          if (cyc_done) begin
            st_q <= FPH_S_PH2;
          end
        end
        FPH_S_PH2: begin
          if (ph2 == FPH_PH_PAGE && cyc_done && pcnt_q != 7'h7F) begin
            pcnt_q <= pcnt_q + 7'h01; // 128 data writes follow 41H
          end else if (ph2 == FPH_PH_NONE || cyc_done) begin
            st_q <= do_poll ? FPH_S_POLL : FPH_S_IDLE;
          end
        end
        FPH_S_POLL: begin
          // Each poll is a whole new read cycle
          if (poll_end) begin
            st_q <= FPH_S_IDLE;
          end
        end
        default: st_q <= FPH_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Device state mirror and sticky fail bits
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !rp_q) begin
      mode_q <= FPH_MODE_ARRAY;
      dstat_q <= `FPH_SR_INIT;
      fail_q <= 3'h0;
    end else begin
      if (stat_done) begin
        dstat_q <= stat_rd;
      end
      // New failure wins over a clear in the same cycle
      fail_q <= (fail_q & ~{3{seq_end && op_q == FPH_OP_CLR_STAT}})
                | ({3{stat_done}} & {stat_rd[`FPH_SR_ERASE_FAIL],
                   stat_rd[`FPH_SR_PROG_FAIL], stat_rd[`FPH_SR_BLOCK_FAIL]});
      if (st_q == FPH_S_CMD1 && cyc_done) begin
        case (cmd)
          `FPH_CMD_READ_ARRAY: mode_q <= FPH_MODE_ARRAY;
          `FPH_CMD_READ_ID: mode_q <= FPH_MODE_ID;
          `FPH_CMD_READ_STAT: mode_q <= FPH_MODE_STAT;
          default: mode_q <= mode_q;
        endcase
      end
      if (st_q == FPH_S_POLL) begin
        mode_q <= FPH_MODE_STAT; // Running engine answers with status
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q <= FPH_OP_READ_ARRAY;
      addr_q <= 20'h00000;
      wdata_q <= 16'h0000;
      rp_q <= 1'b0; // Reset pin low during power-up
      wp_q <= 1'b0;
      refused_q <= 1'b0;
      pidx_q <= 7'h00;
    end else begin
      if (go && !go_ok) begin
        refused_q <= 1'b1;
      end else if (wb_wr && wb_adr_i == `FPH_REG_STAT && wb_wdat[1]) begin
        refused_q <= 1'b0;
      end
      if (wb_wr && st_q == FPH_S_IDLE) begin
        case (wb_adr_i)
          `FPH_REG_CTRL: op_q <= fph_op_e'(4'(wmerge({28'h0, op_q}, wb_dat_i, wb_sel_i)));
          `FPH_REG_ADDR: addr_q <= 20'(wmerge({12'h000, addr_q}, wb_dat_i, wb_sel_i));
          `FPH_REG_WDATA: wdata_q <= 16'(wmerge({16'h0, wdata_q}, wb_dat_i, wb_sel_i));
          `FPH_REG_PINS: begin
            rp_q <= wb_sel_i[0] ? wb_dat_i[0] : rp_q;
            wp_q <= wb_sel_i[0] ? wb_dat_i[1] : wp_q; // Lock override pin
          end
          `FPH_REG_PIDX: pidx_q <= wb_sel_i[0] ? wb_dat_i[6:0] : pidx_q;
          `FPH_REG_PAGE: pidx_q <= pidx_q + 7'h01;
          default: pidx_q <= pidx_q;
        endcase
      end
    end
  end

  // Page data staging for page program
  always_ff @(posedge clk_i) begin
    if (wb_wr && st_q == FPH_S_IDLE && wb_adr_i == `FPH_REG_PAGE) begin
      page_mem[pidx_q] <= wb_dat_i[15:0];
    end
  end

  // Read data capture from array, identifier and status reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else if (st_q == FPH_S_PH2 && ph2 == FPH_PH_READ && cyc_done) begin
      rdata_q <= cyc_rdata; // Busy bank would answer with status
    end
  end

  // Wishbone answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `FPH_REG_CTRL: wb_dat_o <= {28'h0000000, op_q};
          `FPH_REG_STAT: wb_dat_o <= {11'h000, mode_q, fail_q, dstat_q, 5'h00,
                                      pwr_ok, refused_q, st_q != FPH_S_IDLE};
          `FPH_REG_ADDR: wb_dat_o <= {12'h000, addr_q};
          `FPH_REG_WDATA: wb_dat_o <= {16'h0000, wdata_q};
          `FPH_REG_RDATA: wb_dat_o <= {16'h0000, rdata_q};
          `FPH_REG_PINS: wb_dat_o <= {30'h00000000, wp_q, rp_q};
          `FPH_REG_PIDX: wb_dat_o <= {25'h0000000, pidx_q};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Control pins from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_rp_n_o <= 1'b0;
      flash_wp_n_o <= 1'b0;
    end else begin
      flash_rp_n_o <= rp_q;
      flash_wp_n_o <= wp_q;
    end
  end

endmodule // fph_host
`default_nettype wire

// ==== design/fph_map.svh ====
// Register offsets, command codes, status fields and timing counts
`ifndef FPH_MAP_SVH
`define FPH_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FPH_REG_CTRL 5'h00
`define FPH_REG_STAT 5'h04
`define FPH_REG_ADDR 5'h08
`define FPH_REG_WDATA 5'h0C
`define FPH_REG_RDATA 5'h10
`define FPH_REG_PINS 5'h14
`define FPH_REG_PAGE 5'h18
`define FPH_REG_PIDX 5'h1C
`define FPH_CTRL_GO 8

// ----------------------------------------
// Device command codes
// ----------------------------------------
`define FPH_CMD_READ_ARRAY 8'hFF
`define FPH_CMD_READ_ID 8'h90
`define FPH_CMD_READ_STAT 8'h70
`define FPH_CMD_CLR_STAT 8'h50
`define FPH_CMD_ERASE 8'h20
`define FPH_CMD_CONFIRM 8'hD0
`define FPH_CMD_PROGRAM 8'h40
`define FPH_CMD_PAGE_PROG 8'h41
`define FPH_CMD_PAGE_LOAD 8'h74
`define FPH_CMD_PAGE_FLUSH 8'h0E
`define FPH_CMD_PAGE_CLR 8'h55
`define FPH_CMD_SUSPEND 8'hB0

// ----------------------------------------
// Device status fields and reset value
// ----------------------------------------
`define FPH_SR_READY 7
`define FPH_SR_SUSP 6
`define FPH_SR_ERASE_FAIL 5
`define FPH_SR_PROG_FAIL 4
`define FPH_SR_BLOCK_FAIL 3
`define FPH_SR_INIT 8'h80

// ----------------------------------------
// Geometry and timing
// ----------------------------------------
`define FPH_PAGE_WORDS 128
`define FPH_BANK1_LIMIT 20'h1FFFF
`define FPH_CLK_MHZ 20
`define FPH_T_PWR_NS 2000
`define FPH_PWR_CYC ((`FPH_T_PWR_NS * `FPH_CLK_MHZ + 999) / 1000)
`define FPH_T_ACC_NS 90
`define FPH_ACC_CYC ((`FPH_T_ACC_NS * `FPH_CLK_MHZ + 999) / 1000)
`define FPH_RD_CYC (`FPH_ACC_CYC + 3)
`define FPH_T_WP_NS 100
`define FPH_WP_CYC ((`FPH_T_WP_NS * `FPH_CLK_MHZ + 999) / 1000)

`endif

// ==== design/fph_pkg.sv ====
// Types shared by the flash host controller
package fph_pkg;

  // Operations that software can order
  typedef enum logic [3:0] {
    FPH_OP_READ_ARRAY = 4'h0, FPH_OP_READ_ID = 4'h1,
    FPH_OP_READ_STAT = 4'h2, FPH_OP_CLR_STAT = 4'h3,
    FPH_OP_ERASE = 4'h4, FPH_OP_PROGRAM = 4'h5,
    FPH_OP_PAGE_PROG = 4'h6, FPH_OP_PAGE_LOAD = 4'h7,
    FPH_OP_PAGE_FLUSH = 4'h8, FPH_OP_PAGE_CLR = 4'h9,
    FPH_OP_SUSPEND = 4'hA, FPH_OP_RESUME = 4'hB,
    FPH_OP_READ = 4'hC, FPH_OP_POLL = 4'hD
  } fph_op_e;

  // Second phase of a command sequence
  typedef enum logic [2:0] {
    FPH_PH_NONE = 3'h0, FPH_PH_CONFIRM = 3'h1, FPH_PH_DATA = 3'h2,
    FPH_PH_READ = 3'h3, FPH_PH_PAGE = 3'h4
  } fph_ph_e;

  // Device read mode as seen by the host
  typedef enum logic [1:0] {
    FPH_MODE_ARRAY = 2'h0, FPH_MODE_ID = 2'h1, FPH_MODE_STAT = 2'h2
  } fph_mode_e;

  // One flash bus cycle request
  typedef struct packed {
    logic write;
    logic [19:0] addr;
    logic [15:0] data;
  } fph_req_s;

endpackage

// ==== design/fph_sync2.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fph_sync2 #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule // fph_sync2
`default_nettype wire

// ==== testbench/fph_checker.sv ====
// Pin and bus timing checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fph_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and flash pins
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic [19:0] flash_addr_o,
  input wire logic flash_dq_oe_o,
  input wire logic flash_rp_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answers once, one cycle after the request
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  // Write strobe shape and framing
  a_we_pulse: assert property ($fell(flash_we_n_o) |=> !flash_we_n_o ##1 flash_we_n_o)
    else $error("write pulse length wrong");
  a_we_in_frame: assert property ($rose(flash_we_n_o) |=> $rose(flash_ce_n_o))
    else $error("select not released after write");
  a_we_drive: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o)
    else $error("write without select or data");
  // Reads release the bus and toggle a strobe each time
  a_oe_excl: assert property (!flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o)
    else $error("read while driving");
  a_oe_toggle: assert property ($rose(flash_oe_n_o) |=> $rose(flash_ce_n_o) ##1 flash_oe_n_o)
    else $error("strobes not toggled per read");
  a_addr_held: assert property (!flash_ce_n_o && !$fell(flash_ce_n_o) |-> $stable(flash_addr_o))
    else $error("address moved in a cycle");
  // No pin cycles in power-down or just after it
  a_rp_idle: assert property (!flash_rp_n_o |-> flash_ce_n_o)
    else $error("cycle during power-down");
  a_rp_wait: assert property ($rose(flash_rp_n_o) |-> flash_ce_n_o [*8])
    else $error("cycle too soon after wake");
endmodule // fph_checker
bind fph_host fph_checker i_chk (.*);
`default_nettype wire

// ==== testbench/fph_flash_model.sv ====
// Behavioural flash device answering the host pins
`timescale 1ns/1ps
`default_nettype none
module fph_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00A5, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h005A // Arbitrary value
) (
  // Strobes and control
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rp_n_i,
  input wire logic wp_n_i,
  input wire logic slow_i,
  // Address and data
  input wire logic [19:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [int];
  logic [15:0] pb [int];
  logic [15:0] q = 16'h0000;
  logic [7:0] cmd = 8'h00;
  logic [7:0] sr = 8'h80;
  logic [1:0] mode = 2'h0;
  bit lk [64];
  int busy = 0;
  int b;
  // Released lines show the inverse of the last value
  assign dq_o = (!ce_n_i && !oe_n_i) ? q : ~q;
  // Read value captured at the later falling strobe
  always @(negedge (oe_n_i | ce_n_i)) begin
    sr[7] = (busy == 0);
    if (busy > 0) busy--;
    q = (mode == 2'h2) ? {8'h00, sr} : (mode == 2'h1) ? (addr_i[0] ? PART_ID : MAKER_ID)
      : (mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF);
  end
  // Power-down resets mode and status
  always @(negedge rp_n_i) begin
    mode = 2'h0;
    cmd = 8'h00;
    sr = 8'h80;
  end
  // Commands taken at the first rising strobe
  always @(posedge (we_n_i | ce_n_i)) begin
    b = int'(addr_i[19:14]);
    if (rp_n_i && (cmd == 8'h40 || (cmd == 8'h20 && dq_i[7:0] == 8'hD0))) begin
      if (!(wp_n_i || lk[b]) || (cmd == 8'h40 && addr_i > 20'h1FFFF))
        sr[5:3] = sr[5:3] | ((cmd == 8'h40) ? 3'b011 : 3'b101);
      else if (cmd == 8'h40) mem[addr_i] = dq_i;
      else begin
        foreach (mem[k]) if (k[19:14] == b) mem[k] = 16'hFFFF;
        lk[b] = 1'b1;
      end
      busy = slow_i ? 3 : 0;
      mode = 2'h2;
      cmd = 8'h00;
    end else if (rp_n_i && cmd == 8'h41) begin
      mem[addr_i] = dq_i;
      if (addr_i[6:0] == 7'h7F) begin
        mode = 2'h2;
        cmd = 8'h00;
      end
    end else if (rp_n_i && cmd == 8'h74) begin
      pb[addr_i] = dq_i;
      cmd = 8'h00;
    end else if (rp_n_i && cmd == 8'h0E && dq_i[7:0] == 8'hD0) begin
      foreach (pb[k]) mem[k] = pb[k];
      pb.delete();
      mode = 2'h2;
      cmd = 8'h00;
    end else if (rp_n_i) begin
      case (dq_i[7:0])
        8'hFF: mode = 2'h0;
        8'h90: mode = 2'h1;
        8'h70: mode = 2'h2;
        8'h50: sr[5:3] = 3'b000;
        8'hB0: begin
          sr[6] = 1'b1;
          mode = 2'h2;
        end
        8'hD0: sr[6] = 1'b0;
        default: ;
      endcase
      cmd = dq_i[7:0];
    end
  end
endmodule // fph_flash_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "fph_map.svh"
module tb_top import fph_pkg::*;;
  localparam logic [15:0] ID0 = 16'h00A5; // Arbitrary value
  localparam logic [15:0] ID1 = 16'h005A; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, rdat, r;
  logic ack, ce_n, oe_n, we_n, dqoe, rp_n, wp_n;
  logic [19:0] fa, a0;
  logic [15:0] dqo, mdq, dqi;
  logic [15:0] ref_mem [int];
  logic [31:0] rnd = 32'hBBA8E58D;
  int mismatches = 0, checks_done = 0;
  // Clock and shared data wire
  always #25 clk_i = ~clk_i;
  assign dqi = dqoe ? dqo : mdq;
  fph_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_addr_o(fa),
    .flash_dq_o(dqo), .flash_dq_oe_o(dqoe), .flash_dq_i(dqi), .flash_rp_n_o(rp_n),
    .flash_wp_n_o(wp_n));
  fph_flash_model #(.MAKER_ID(ID0), .PART_ID(ID1)) i_flash (.ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .rp_n_i(rp_n), .wp_n_i(wp_n), .slow_i(slow), .addr_i(fa), .dq_i(dqo),
    .dq_o(mdq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Order one operation and wait until not busy
  task automatic op(input fph_op_e o, input logic [19:0] a, input logic [15:0] d);
    wb(1'b1, `FPH_REG_ADDR, {12'h000, a});
    wb(1'b1, `FPH_REG_WDATA, {16'h0000, d});
    wb(1'b1, `FPH_REG_CTRL, {28'h0, o});
    wb(1'b1, `FPH_REG_CTRL, {23'h0, 1'b1, 4'h0, o});
    do begin
      wb(1'b0, `FPH_REG_STAT, 32'h0);
    end while (r[0] === 1'b1);
  endtask
  task automatic rdchk(input fph_op_e o, input logic [19:0] a, input logic [15:0] e);
    op(o, a, 16'h0000);
    wb(1'b0, `FPH_REG_RDATA, 32'h0);
    chk(r[15:0], e);
  endtask
  // Hang guard
  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    op(FPH_OP_READ_STAT, 20'h0, 16'h0);
    chk(r[1:0], 2'b10);
    wb(1'b1, `FPH_REG_STAT, 32'h2);
    wb(1'b1, `FPH_REG_PINS, 32'h3);
    rdchk(FPH_OP_READ_STAT, 20'h0, 16'h0080);
    rdchk(FPH_OP_READ_ID, 20'h0, ID0);
    rdchk(FPH_OP_READ_ID, 20'h1, ID1);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      slow <= rnd[20];
      a0 = {3'b000, rnd[16:0]};
      ref_mem[a0] = rnd[31:16];
      op(FPH_OP_PROGRAM, a0, rnd[31:16]);
      chk(r[20:19], 2'h2);
      op(FPH_OP_READ_ARRAY, a0, 16'h0);
      rdchk(FPH_OP_READ, a0, ref_mem[a0]);
    end
    wb(1'b1, `FPH_REG_PINS, 32'h1);
    op(FPH_OP_ERASE, a0, 16'h0);
    chk(r[18:16], 3'b101);
    op(FPH_OP_READ_STAT, a0, 16'h0);
    chk(r[18:16], 3'b101);
    op(FPH_OP_READ_ARRAY, a0, 16'h0);
    rdchk(FPH_OP_READ, a0, ref_mem[a0]);
    op(FPH_OP_CLR_STAT, a0, 16'h0);
    chk(r[18:16], 3'b000);
    wb(1'b1, `FPH_REG_PINS, 32'h3);
    op(FPH_OP_ERASE, a0, 16'h0);
    foreach (ref_mem[k]) if (k[19:14] == a0[19:14]) ref_mem[k] = 16'hFFFF;
    op(FPH_OP_READ_ARRAY, a0, 16'h0);
    rdchk(FPH_OP_READ, a0, ref_mem[a0]);
    wb(1'b1, `FPH_REG_PIDX, 32'h0);
    for (int i = 0; i < 128; i++) begin
      rnd = lfsr(rnd);
      ref_mem[20'h40000 + i] = rnd[15:0];
      wb(1'b1, `FPH_REG_PAGE, rnd);
    end
    op(FPH_OP_PAGE_PROG, 20'h40000, 16'h0);
    rnd = lfsr(rnd);
    ref_mem[20'h00100] = rnd[15:0];
    op(FPH_OP_PAGE_LOAD, 20'h00100, rnd[15:0]);
    op(FPH_OP_PAGE_FLUSH, 20'h00100, 16'h0);
    op(FPH_OP_READ_ARRAY, 20'h0, 16'h0);
    rdchk(FPH_OP_READ, 20'h40000, ref_mem[20'h40000]);
    rdchk(FPH_OP_READ, 20'h4007F, ref_mem[20'h4007F]);
    rdchk(FPH_OP_READ, 20'h00100, ref_mem[20'h00100]);
    op(FPH_OP_SUSPEND, a0, 16'h0);
    chk(r[14], 1'b1);
    op(FPH_OP_RESUME, a0, 16'h0);
    op(FPH_OP_READ_STAT, a0, 16'h0);
    chk(r[14], 1'b0);
    wb(1'b1, `FPH_REG_PINS, 32'h1);
    op(FPH_OP_ERASE, a0, 16'h0);
    chk(r[18:16], 3'b000);
    op(FPH_OP_PROGRAM, 20'h80000, 16'h1234);
    chk(r[1:0], 2'b10);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
